// ==== design/rtc_pin_pkg.sv ====
// Shared constants and types for the clock-output, alarm pin and reset block.
package rtc_pin_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 25_000_000;
    localparam int OSF_DELAY_MS = 100;
    localparam int RST_ACTIVE_MS = 250;
    localparam int PB_DEBOUNCE_MS = 250;
    localparam int OSF_CYCLES = (CLK_HZ / 1000) * OSF_DELAY_MS;
    localparam int RST_CYCLES = (CLK_HZ / 1000) * RST_ACTIVE_MS;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * PB_DEBOUNCE_MS;

    // ==========================================================
    // Control register
    // ==========================================================
    localparam logic [7:0] CTRL_OFFSET = 8'h0e;
    localparam logic [7:0] CTRL_RESET = 8'h1c;
    localparam int CTRL_OSC_DIS_BIT = 7;
    localparam int CTRL_RATE_HI_BIT = 4;
    localparam int CTRL_RATE_LO_BIT = 3;
    localparam int CTRL_IRQ_SEL_BIT = 2;
    localparam int CTRL_ALM2_EN_BIT = 1;
    localparam int CTRL_ALM1_EN_BIT = 0;

    // ==========================================================
    // Square-wave half periods in oscillator cycles
    // ==========================================================
    localparam logic [14:0] HALF_1HZ = 15'h4000;
    localparam logic [14:0] HALF_1KHZ = 15'h0010;
    localparam logic [14:0] HALF_4KHZ = 15'h0004;
    localparam logic [14:0] HALF_8KHZ = 15'h0002;

    typedef enum {RS_FAIL, RS_HOLD, RS_IDLE, RS_PRESS} rst_state_t;
endpackage

// ==== design/level_debounce.sv ====
// Level filter that accepts a new input level only after it has been stable.
module level_debounce #(
    parameter int CYCLES = 16
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic level_i,
    output logic stable_o
);
    logic [31:0] cnt_q;
    logic stable_q;

    // ==========================================================
    // Stability counter
    // ==========================================================
    // Any bounce restarts the count, so only a clean level is accepted.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= 32'h0000_0000;
            stable_q <= 1'b0;
        end
        else if (level_i == stable_q)
        begin
            cnt_q <= 32'h0000_0000;
        end
        else if (cnt_q == 32'(CYCLES - 1))
        begin
            cnt_q <= 32'h0000_0000;
            stable_q <= level_i;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    assign stable_o = stable_q;
endmodule

// ==== design/rtc_pin_ctrl.sv ====
// Clock output gating, alarm or square-wave pin, and reset pin supervisor.
// Functional notes
// R1: 32 kHz output held low when either clock output enable bit is 0.
// R2: Interrupt select bit in control register 0Eh chooses pin function.
// R3: Select 0 drives a square wave chosen by the two rate bits.
// R4: Select 1 pulls the pin low on an enabled alarm match.
// R5: Reset leaves interrupt select at 1 with both alarms disabled.
// R6: Shared pin is open drain: only pulled low or released.
// R7: Reset pin driven low once supply falls below the fail threshold.
// R8: After supply recovers, reset stays low for the active time.
// R9: A debounced low on the reset pin is a reset request.
// R10: First power-up or stopped oscillator releases reset at once.
// R11: Oscillator disable bit at 1 bypasses the recovery delay.
// R12: Stop flag sets after oscillator stopped for the detection interval.
// R13: Register writes are accepted only while chip select is low.
// R14: Stop detection interval is nominally 100 ms.
// R15: After a button release, reset is held low for the active time.
// R16: Alarm interrupt stays until its flag is cleared or alarm disabled.
module rtc_pin_ctrl #(
    parameter int OSF_CYCLES = rtc_pin_pkg::OSF_CYCLES,
    parameter int RST_CYCLES = rtc_pin_pkg::RST_CYCLES,
    parameter int DEBOUNCE_CYCLES = rtc_pin_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic osc_clk_i,
    input wire logic power_good_i,
    input wire logic cs_n_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic clock_out_enable_i,
    input wire logic battery_clock_out_enable_i,
    input wire logic [1:0] alarm_match_i,
    input wire logic [1:0] alarm_clr_i,
    input wire logic osf_clr_i,
    output logic [1:0] alarm_flag_o,
    output logic oscillator_stop_flag_o,
    output logic clk32_o,
    output logic irq_or_wave_pin_out_o,
    output logic irq_or_wave_pin_oe_o,
    input wire logic rst_pin_n_i,
    output logic rst_pin_out_o,
    output logic rst_pin_oe_o
);
    logic [3:0] sync1_q, sync2_q;
    logic osc_prev_q, osc_edge, pg_s, cs_n_s, pin_low_s, osc_dis;
    logic [7:0] ctrl_q, rdata_q;
    logic [1:0] alarm_flag_q;
    logic [31:0] idle_cnt_q, hold_cnt_q;
    logic osc_stopped_q, osf_q, wave_q, first_q;
    logic [14:0] wave_cnt_q;
    logic button_low, pressed, drive_rst, irq_active;
    rtc_pin_pkg::rst_state_t state_q, state_d;

    // Half period of the square wave for a rate code.
    function automatic logic [14:0] half_period(input logic [1:0] rate);
        case (rate)
            2'b00: half_period = rtc_pin_pkg::HALF_1HZ;
            2'b01: half_period = rtc_pin_pkg::HALF_1KHZ;
            2'b10: half_period = rtc_pin_pkg::HALF_4KHZ;
            default: half_period = rtc_pin_pkg::HALF_8KHZ;
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Second stage only is read; a third flop gives the oscillator edge.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_q <= 4'h3;
            sync2_q <= 4'h3;
            osc_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {~rst_pin_n_i, osc_clk_i, power_good_i, cs_n_i};
            sync2_q <= sync1_q;
            osc_prev_q <= sync2_q[2];
        end
    end

    assign cs_n_s = sync2_q[0];
    assign pg_s = sync2_q[1];
    assign osc_edge = sync2_q[2] & ~osc_prev_q;
    assign pin_low_s = sync2_q[3];
    assign osc_dis = ctrl_q[rtc_pin_pkg::CTRL_OSC_DIS_BIT];

    // ==========================================================
    // Control register
    // ==========================================================
    // The serial engine only writes while the device is selected.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= rtc_pin_pkg::CTRL_RESET; // R5
            rdata_q <= 8'h00;
        end
        else
        begin
            if (reg_wr_i && !cs_n_s && reg_addr_i == rtc_pin_pkg::CTRL_OFFSET)
                ctrl_q <= reg_wdata_i; // R13 R2
            rdata_q <= (reg_addr_i == rtc_pin_pkg::CTRL_OFFSET) ? ctrl_q : 8'h00;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ==========================================================
    // Alarm flags and oscillator stop detection
    // ==========================================================
    // A match in the clearing cycle wins, so no alarm is lost.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
            alarm_flag_q <= 2'b00;
        else
            alarm_flag_q <= (alarm_flag_q & ~alarm_clr_i) | alarm_match_i; // R16
    end

    // Stop flag comes up set after reset because time is not yet trusted.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            idle_cnt_q <= 32'h0000_0000;
            osc_stopped_q <= 1'b1;
            osf_q <= 1'b1;
        end
        else
        begin
            if (osc_edge)
            begin
                idle_cnt_q <= 32'h0000_0000;
                osc_stopped_q <= 1'b0;
            end
            else if (idle_cnt_q != 32'(OSF_CYCLES - 1))
                idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
            else
                osc_stopped_q <= 1'b1; // R12 R14
            if (!osc_edge && idle_cnt_q == 32'(OSF_CYCLES - 1))
                osf_q <= 1'b1; // R12
            else if (osf_clr_i)
                osf_q <= 1'b0;
        end
    end

    assign alarm_flag_o = alarm_flag_q;
    assign oscillator_stop_flag_o = osf_q;

    // ==========================================================
    // Square wave and shared pin
    // ==========================================================
    // The wave follows oscillator edges, so it freezes if the crystal stops.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wave_cnt_q <= 15'h0000;
            wave_q <= 1'b1;
        end
        else if (osc_edge)
        begin
            if (wave_cnt_q >= half_period(ctrl_q[4:3]) - 15'h0001)
            begin
                wave_cnt_q <= 15'h0000;
                wave_q <= ~wave_q; // R3
            end
            else
                wave_cnt_q <= wave_cnt_q + 15'h0001;
        end
    end

    assign irq_active = |(alarm_flag_q & ctrl_q[1:0]); // R4 R16
    // Pin function is picked by the select bit; only a low is ever driven.
    assign irq_or_wave_pin_oe_o = ctrl_q[rtc_pin_pkg::CTRL_IRQ_SEL_BIT]
                                ? irq_active : ~wave_q; // R2 R3 R4
    assign irq_or_wave_pin_out_o = 1'b0; // R6
    assign clk32_o = sync2_q[2] & clock_out_enable_i
                   & battery_clock_out_enable_i; // R1

    // ==========================================================
    // Reset pin supervisor
    // ==========================================================
    // Our own drive is masked so it is never mistaken for the button.
    assign button_low = pin_low_s & ~drive_rst;

    level_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_button (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .level_i(button_low),
        .stable_o(pressed)
    );

    // Next-state selection for the reset pin.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rtc_pin_pkg::RS_FAIL:
                if (pg_s)
                begin
                    if (first_q || osc_dis || osc_stopped_q)
                        state_d = rtc_pin_pkg::RS_IDLE; // R10 R11
                    else
                        state_d = rtc_pin_pkg::RS_HOLD; // R8
                end
            rtc_pin_pkg::RS_HOLD:
                if (hold_cnt_q == 32'(RST_CYCLES - 1))
                    state_d = rtc_pin_pkg::RS_IDLE; // R8 R15
            rtc_pin_pkg::RS_IDLE:
                if (pressed)
                    state_d = rtc_pin_pkg::RS_PRESS; // R9
            rtc_pin_pkg::RS_PRESS:
                if (!pressed)
                    state_d = rtc_pin_pkg::RS_HOLD; // R15
            default:
                state_d = rtc_pin_pkg::RS_FAIL;
        endcase
        if (!pg_s)
            state_d = rtc_pin_pkg::RS_FAIL; // R7
    end

    // State, hold counter and first-power memory.
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= rtc_pin_pkg::RS_FAIL;
            hold_cnt_q <= 32'h0000_0000;
            first_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == rtc_pin_pkg::RS_HOLD)
                hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            else
                hold_cnt_q <= 32'h0000_0000;
            if (state_q == rtc_pin_pkg::RS_FAIL && pg_s)
                first_q <= 1'b0;
        end
    end

    assign drive_rst = (state_q == rtc_pin_pkg::RS_FAIL)
                     || (state_q == rtc_pin_pkg::RS_HOLD); // R7 R8
    assign rst_pin_oe_o = drive_rst;
    assign rst_pin_out_o = 1'b0;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    clk_out_gate_a: assert property ( // R1
        !(clock_out_enable_i && battery_clock_out_enable_i) |-> !clk32_o)
        else $error("clock output not gated low");
    wave_route_a: assert property ( // R3
        !ctrl_q[rtc_pin_pkg::CTRL_IRQ_SEL_BIT] |->
        irq_or_wave_pin_oe_o == !wave_q)
        else $error("square wave not on shared pin");
    irq_route_a: assert property ( // R4
        ctrl_q[2] && alarm_match_i[0] && ctrl_q[0] && !alarm_clr_i[0]
        && !reg_wr_i |=> irq_or_wave_pin_oe_o)
        else $error("enabled alarm did not pull pin low");
    open_drain_a: assert property (!irq_or_wave_pin_out_o) // R6
        else $error("shared pin driven high");
    power_fail_a: assert property (!pg_s |=> rst_pin_oe_o ##1 1'b1) // R7
        else $error("reset not driven on power fail");
    hold_length_a: assert property ( // R8
        state_q == rtc_pin_pkg::RS_HOLD && state_d == rtc_pin_pkg::RS_IDLE
        |-> hold_cnt_q == 32'(RST_CYCLES - 1))
        else $error("reset hold length wrong");
    delay_bypass_a: assert property ( // R11
        state_q == rtc_pin_pkg::RS_FAIL && pg_s && osc_dis
        |=> state_q == rtc_pin_pkg::RS_IDLE && !rst_pin_oe_o)
        else $error("disabled oscillator did not bypass delay");
    first_power_a: assert property ( // R10
        state_q == rtc_pin_pkg::RS_FAIL && pg_s && first_q
        |=> !rst_pin_oe_o && !first_q)
        else $error("first power-up did not release reset");
    osf_set_a: assert property ( // R12
        !osc_edge && idle_cnt_q == 32'(OSF_CYCLES - 1) |=> osf_q)
        else $error("stop flag not set");
    cs_gate_a: assert property (cs_n_s |=> $stable(ctrl_q)) // R13
        else $error("control written while deselected");
    release_hold_a: assert property ( // R15
        state_q == rtc_pin_pkg::RS_PRESS && !pressed && pg_s
        |=> rst_pin_oe_o[*2])
        else $error("button release did not start hold");
    alarm_sticky_a: assert property ( // R16
        alarm_flag_q[1] && !alarm_clr_i[1] |=> alarm_flag_q[1])
        else $error("alarm flag dropped without clear");

    hold_seen_c: cover property (state_q == rtc_pin_pkg::RS_HOLD
        ##1 state_q == rtc_pin_pkg::RS_IDLE);
    press_seen_c: cover property (state_q == rtc_pin_pkg::RS_PRESS);
    wave_seen_c: cover property (!ctrl_q[2] && $fell(wave_q));
endmodule

// ==== verif/rtc_pin_partner.sv ====
// Far-side model: oscillator source, pushbutton switch and pin pull-ups.
module rtc_pin_partner (
    input wire logic osc_run_i,
    input wire logic button_i,
    input wire logic rst_oe_i,
    input wire logic irq_oe_i,
    output logic osc_clk_o,
    output logic rst_pin_n_o,
    output logic irq_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Oscillator
    // ==========================================================
    // A halted crystal stands still, so the clock parks low when stopped.
    initial
    begin
        osc_clk_o = 1'b0;
        forever
        begin
            #200;
            osc_clk_o = osc_run_i ? ~osc_clk_o : 1'b0;
        end
    end
    // Both lines have pull-ups: a released line reads high, never stale.
    assign rst_pin_n_o = ~(rst_oe_i | button_i);
    assign irq_pin_n_o = ~irq_oe_i;
endmodule

// ==== verif/rtc_pin_ctrl_tb.sv ====
// Self-checking bench for the clock-output, alarm pin and reset block.
module rtc_pin_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSCILLATOR_STOP_FLAG = 40;
    localparam int RST = 20;
    localparam int DEB = 10;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic power_good_i = 1'b1;
    logic cs_n_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h0e;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic en_a = 1'b1;
    logic en_b = 1'b1;
    logic [1:0] match = 2'b00;
    logic [1:0] aclr = 2'b00;
    logic osf_clr = 1'b0;
    logic osc_run = 1'b1;
    logic button = 1'b0;
    logic [1:0] alarm_flag_o;
    logic osf_o, clk32_o, irq_out, irq_oe, rst_out, rst_oe;
    logic osc_clk, rst_pin_n, irq_pin_n;
    logic prev_oe = 1'b0;
    logic [7:0] ctrl_m = rtc_pin_pkg::CTRL_RESET;
    logic [1:0] flg_m = 2'b00;
    logic [7:0] d;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int ntog = 0;
    int hi = 0;
    int half_t[4] = '{rtc_pin_pkg::HALF_1HZ, rtc_pin_pkg::HALF_1KHZ,
        rtc_pin_pkg::HALF_4KHZ, rtc_pin_pkg::HALF_8KHZ};

    rtc_pin_ctrl #(.OSF_CYCLES(OSCILLATOR_STOP_FLAG), .RST_CYCLES(RST),
        .DEBOUNCE_CYCLES(DEB)) dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .osc_clk_i(osc_clk),
        .power_good_i(power_good_i), .cs_n_i(cs_n_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .clock_out_enable_i(en_a),
        .battery_clock_out_enable_i(en_b), .alarm_match_i(match),
        .alarm_clr_i(aclr), .osf_clr_i(osf_clr),
        .alarm_flag_o(alarm_flag_o), .oscillator_stop_flag_o(osf_o),
        .clk32_o(clk32_o), .irq_or_wave_pin_out_o(irq_out),
        .irq_or_wave_pin_oe_o(irq_oe), .rst_pin_n_i(rst_pin_n),
        .rst_pin_out_o(rst_out), .rst_pin_oe_o(rst_oe));
    rtc_pin_partner far (.osc_run_i(osc_run), .button_i(button),
        .rst_oe_i(rst_oe), .irq_oe_i(irq_oe), .osc_clk_o(osc_clk),
        .rst_pin_n_o(rst_pin_n), .irq_pin_n_o(irq_pin_n));

    // ==========================================================
    // Clock, watchdog and pin monitor
    // ==========================================================
    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Pins must never be driven high; the watchdog cuts a hung run short.
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (irq_oe !== prev_oe)
            ntog++;
        prev_oe = irq_oe;
        if (rstn_i && (irq_out !== 1'b0 || rst_out !== 1'b0))
        begin
            n_fail++;
            $display("Error %0t: open-drain data not low", $time);
        end
        if (cyc == 20000)
        begin
            n_fail++;
            $display("Error %0t: timeout", $time);
            print_verdict();
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Chip select is synchronised, so it leads the strobe by three edges.
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic c);
        cs_n_i <= c;
        tick(3);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        tick(1);
        reg_wr_i <= 1'b0;
        reg_addr_i <= 8'h0e;
        cs_n_i <= 1'b1;
        tick(1);
        if (!c && a == 8'h0e)
            ctrl_m = v;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        tick(3);
        chk(reg_rdata_o, (a == 8'h0e) ? ctrl_m : 8'h00);
        reg_addr_i <= 8'h0e;
    endtask
    // Set wins over clear in one cycle; the pin follows enabled flags.
    task automatic alm(input logic [1:0] m, input logic [1:0] c);
        match <= m;
        aclr <= c;
        tick(1);
        match <= 2'b00;
        aclr <= 2'b00;
        flg_m = (flg_m | m) & ~(c & ~m);
        tick(3);
        chk(8'(alarm_flag_o), 8'(flg_m));
        chk(8'(!irq_pin_n), 8'(ctrl_m[2] && (flg_m & ctrl_m[1:0]) != 0));
    endtask
    task automatic pwr(input bit hold);
        power_good_i <= 1'b0;
        tick(4);
        chk(8'(rst_oe), 8'h01);
        power_good_i <= 1'b1;
        tick(hold ? RST + 3 : 4);
        chk(8'(rst_oe), 8'(hold));
        tick(1);
        chk(8'(rst_oe), 8'h00);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        void'($urandom(71));
        tick(8);
        rstn_i <= 1'b1;
        tick(3);
        rd(8'h0e);
        chk(8'(irq_pin_n), 8'h01);
        chk(8'(rst_oe), 8'h00);
        d = 8'($urandom);
        wr(8'h0e, d, 1'b1);
        rd(8'h0e);
        wr(8'($urandom_range(255, 16)), d, 1'b0);
        rd(8'h33);
        for (int k = 0; k < 4; k++)
        begin
            en_a <= k[0];
            en_b <= k[1];
            tick(3);
            hi = 0;
            for (int i = 0; i < 30; i++)
            begin
                @(posedge clk_sys_i);
                if (clk32_o !== 1'b0)
                    hi++;
            end
            chk(8'(hi != 0), 8'(k == 3));
        end
        wr(8'h0e, 8'h05, 1'b0);
        rd(8'h0e);
        alm(2'b01, 2'b00);
        alm(2'b10, 2'b00);
        alm(2'b00, 2'b01);
        alm(2'b01, 2'b00);
        wr(8'h0e, 8'h04, 1'b0);
        alm(2'b00, 2'b00);
        alm(2'b00, 2'b11);
        wr(8'h0e, 8'h06, 1'b0);
        alm(2'b10, 2'b10);
        alm(2'b00, 2'b10);
        // The wave toggles once per half period of oscillator edges.
        for (int r = 0; r < 4; r++)
        begin
            wr(8'h0e, 8'(r << 3), 1'b0);
            repeat (4) @(posedge osc_clk);
            ntog = 0;
            repeat (32) @(posedge osc_clk);
            chk(8'(ntog > 32 / half_t[r] + 1 || ntog + 1 < 32 / half_t[r]),
                8'h00);
            @(posedge clk_sys_i);
        end
        osf_clr <= 1'b1;
        tick(1);
        osf_clr <= 1'b0;
        tick(2);
        chk(8'(osf_o), 8'h00);
        wr(8'h0e, 8'h1c, 1'b0);
        pwr(1'b1);
        wr(8'h0e, 8'h9c, 1'b0);
        pwr(1'b0);
        wr(8'h0e, 8'h1c, 1'b0);
        button <= 1'b1;
        tick(DEB + 10);
        chk(8'(rst_oe), 8'h00);
        button <= 1'b0;
        tick(DEB + 6);
        chk(8'(rst_oe), 8'h01);
        tick(RST - 3);
        chk(8'(rst_oe), 8'h01);
        tick(1);
        chk(8'(rst_oe), 8'h00);
        osc_run <= 1'b0;
        tick(OSCILLATOR_STOP_FLAG - 12);
        chk(8'(osf_o), 8'h00);
        tick(22);
        chk(8'(osf_o), 8'h01);
        pwr(1'b0);
        osc_run <= 1'b1;
        tick(4);
        print_verdict();
    end
endmodule
